// File: bmc_cmd_core.v
// Brake and manual control command handler with its brake and button sequencers.
`timescale 1ns/1ps
`default_nettype none
`include "bmc_defs.vh"
// ==========================================
module bmc_cmd_core #(
    parameter MS_CYCLES = `BMC_MS_NS / `BMC_CLK_NS
) (
    input  wire        clk_sys,
    input  wire        rst_n,
    input  wire [7:0]  rx_data,
    input  wire        rx_valid,
    output wire        rx_ready,
    output reg  [7:0]  tx_data,
    output reg         tx_valid,
    input  wire        tx_ready,
    input  wire [3:0]  reg_addr,
    input  wire [31:0] reg_wdata,
    input  wire        reg_wr,
    input  wire        reg_rd,
    output reg  [31:0] reg_rdata,
    input  wire        power_req,
    input  wire        motor_stopped,
    input  wire        stepper_motor,
    output reg         motor_power_en,
    output reg         brake_release,
    output reg         move_ready,
    input  wire        btn_left_in,
    input  wire        btn_right_in,
    input  wire        stick_pos,
    input  wire        stick_neg,
    output reg         man_run,
    output reg         man_dir,
    output reg  [31:0] man_speed_full,
    output reg  [7:0]  man_speed_frac,
    output reg  [3:0]  man_speed_index,
    output reg         man_profile_step,
    output reg  [31:0] pos_shift,
    output reg  [15:0] pos_shift_frac
);
    localparam S_IDLE = 2'd0;
    localparam S_RX   = 2'd1;
    localparam S_TX   = 2'd2;
    localparam B_OFF = 3'd0;
    localparam B_PWRUP = 3'd1;
    localparam B_SETTLE = 3'd2;
    localparam B_READY = 3'd3;
    localparam B_STOPW = 3'd4;
    localparam B_ENG = 3'd5;
    localparam B_HOLD = 3'd6;
    localparam M_IDLE = 2'd0;
    localparam M_CLICK = 2'd1;
    localparam M_RUN = 2'd2;

    reg [7:0]  brk_mem [0:`BMC_BRK_USED-1];
    reg [7:0]  ctl_mem [0:`BMC_CTL_USED-1];
    reg [7:0]  rx_buf  [0:88];
    reg [1:0]  st_r;
    reg [31:0] code_r;
    reg [2:0]  seen_r;
    reg [6:0]  cnt_r;
    reg [6:0]  len_r;
    reg        is_ctl_r;
    reg        is_read_r;
    reg [15:0] sum_r;
    reg        ctrl_r;
    reg [16:0] div_r;
    reg        ms_tick;
    reg [2:0]  bst_r;
    reg [2:0]  bst_nxt;
    reg [15:0] bt_r;
    reg [1:0]  mst_r;
    reg [15:0] mt_r;
    reg        lp_r;
    reg        rp_r;
    integer    k;

    // ==========================================
    // Millisecond enable
    always @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            div_r <= 17'h0;
            ms_tick <= 1'b0;
        end else if (div_r == MS_CYCLES - 1) begin
            div_r <= 17'h0;
            ms_tick <= 1'b1;
        end else begin
            div_r <= div_r + 17'h1;
            ms_tick <= 1'b0;
        end
    end

    // ==========================================
    // Settings field access
    function [15:0] brk_delay;
        input [1:0] i;
        brk_delay = {brk_mem[{i, 1'b1}], brk_mem[{i, 1'b0}]};
    endfunction

    function [15:0] ctl_half;
        input [6:0] o;
        ctl_half = {ctl_mem[o + 7'd1], ctl_mem[o]};
    endfunction

    wire [7:0]  bflags  = brk_mem[`BMC_BRK_FLAGS];
    wire [7:0]  cflags  = ctl_mem[`BMC_OFS_FLAGS];
    wire [1:0]  mode    = cflags[1:0];
    wire        brk_en  = bflags[`BMC_BFLAG_ENABLE];
    wire        pwr_want = power_req | ctrl_r;
    wire [15:0] click_ms = ctl_half(7'd`BMC_OFS_CLICK);
    wire [4:0]  mt_idx2 = {man_speed_index, 1'b0};
    wire [15:0] tmo_ms  = ctl_half(7'd`BMC_OFS_TMO + {2'b00, mt_idx2});
    wire [5:0]  sp_ofs  = {man_speed_index, 2'b00};
    wire [3:0]  nxt_idx = man_speed_index + 4'd1;
    wire [5:0]  nx_ofs  = {nxt_idx, 2'b00};
    wire        nxt_zero = ({ctl_mem[nx_ofs + 6'd3], ctl_mem[nx_ofs + 6'd2],
                            ctl_mem[nx_ofs + 6'd1], ctl_mem[nx_ofs]} == 32'h0) &&
                           (ctl_mem[`BMC_OFS_FRAC + nxt_idx] == 8'h0);
    wire        lp = btn_left_in ^ cflags[`BMC_CFLAG_LEFT];
    wire        rp = btn_right_in ^ cflags[`BMC_CFLAG_RIGHT];

    // ==========================================
    // Command framing
    wire [31:0] code_nxt = {rx_data, code_r[31:8]};
    wire        full4 = (seen_r >= 3'd3);
    wire        take = rx_valid && (st_r != S_TX);
    wire        tx_adv = !tx_valid || tx_ready;
    assign rx_ready = (st_r != S_TX);

    reg [7:0] tx_byte;
    reg       tx_in_sum;
    reg [6:0] p;
    always @* begin
        p = cnt_r - `BMC_LEN_CODE;
        tx_in_sum = 1'b0;
        if (cnt_r < `BMC_LEN_CODE) begin
            tx_byte = code_r[cnt_r[1:0]*8 +: 8];
        end else if (cnt_r == len_r - 7'd2) begin
            tx_byte = sum_r[7:0];
        end else if (cnt_r == len_r - 7'd1) begin
            tx_byte = sum_r[15:8];
        end else begin
            tx_in_sum = 1'b1;
            if (is_ctl_r) begin
                tx_byte = (p < `BMC_CTL_USED) ? ctl_mem[p] : 8'h00;
            end else begin
                tx_byte = (p < `BMC_BRK_USED) ? brk_mem[p[3:0]] : 8'h00;
            end
        end
    end

    always @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            st_r <= S_IDLE;
            code_r <= 32'h0;
            seen_r <= 3'h0;
            cnt_r <= 7'h0;
            len_r <= 7'h0;
            is_ctl_r <= 1'b0;
            is_read_r <= 1'b0;
            sum_r <= 16'h0;
            tx_valid <= 1'b0;
            tx_data <= 8'h00;
            for (k = 0; k < `BMC_BRK_USED; k = k + 1)
                brk_mem[k] <= 8'h00;
            for (k = 0; k < `BMC_CTL_USED; k = k + 1)
                ctl_mem[k] <= 8'h00;
        end else begin
            case (st_r)
                S_IDLE: begin
                    if (take) begin
                        code_r <= code_nxt;
                        seen_r <= full4 ? 3'd4 : seen_r + 3'd1;
                        cnt_r <= 7'h0;
                        sum_r <= 16'h0;
                        if (full4 && (code_nxt == `BMC_CODE_GET_BRAKE ||
                                      code_nxt == `BMC_CODE_GET_CTL)) begin
                            st_r <= S_TX;
                            is_read_r <= 1'b1;
                            is_ctl_r <= (code_nxt == `BMC_CODE_GET_CTL);
                            len_r <= (code_nxt == `BMC_CODE_GET_CTL) ?
                                     `BMC_LEN_CTL : `BMC_LEN_BRAKE;
                        end else if (full4 && (code_nxt == `BMC_CODE_SET_BRAKE ||
                                               code_nxt == `BMC_CODE_SET_CTL)) begin
                            st_r <= S_RX;
                            is_read_r <= 1'b0;
                            is_ctl_r <= (code_nxt == `BMC_CODE_SET_CTL);
                            len_r <= (code_nxt == `BMC_CODE_SET_CTL) ?
                                     `BMC_LEN_CTL - `BMC_LEN_CODE :
                                     `BMC_LEN_BRAKE - `BMC_LEN_CODE;
                        end
                    end
                end
                S_RX: begin
                    if (take) begin
                        rx_buf[cnt_r] <= rx_data;
                        cnt_r <= cnt_r + 7'd1;
                        if (cnt_r < len_r - 7'd2)
                            sum_r <= sum_r + {8'h00, rx_data};
                        if (cnt_r == len_r - 7'd1) begin
                            seen_r <= 3'h0;
                            cnt_r <= 7'h0;
                            sum_r <= 16'h0;
                            if ({rx_data, rx_buf[cnt_r - 7'd1]} == sum_r) begin
                                st_r <= S_TX;
                                len_r <= `BMC_LEN_ACK;
                                if (is_ctl_r) begin
                                    for (k = 0; k < `BMC_CTL_USED; k = k + 1)
                                        ctl_mem[k] <= rx_buf[k];
                                end else begin
                                    for (k = 0; k < `BMC_BRK_USED; k = k + 1)
                                        brk_mem[k] <= rx_buf[k];
                                end
                            end else begin
                                st_r <= S_IDLE;
                            end
                        end
                    end
                end
                S_TX: begin
                    if (tx_adv) begin
                        if (cnt_r < len_r) begin
                            tx_valid <= 1'b1;
                            tx_data <= tx_byte;
                            cnt_r <= cnt_r + 7'd1;
                            if (tx_in_sum)
                                sum_r <= sum_r + {8'h00, tx_byte};
                        end else begin
                            tx_valid <= 1'b0;
                            st_r <= S_IDLE;
                            seen_r <= 3'h0;
                        end
                    end
                end
                default: st_r <= S_IDLE;
            endcase
        end
    end

    // ==========================================
    // Brake sequencer
    always @* begin
        bst_nxt = bst_r;
        case (bst_r)
            B_OFF: begin
                if (pwr_want)
                    bst_nxt = brk_en ? B_PWRUP : B_READY;
            end
            B_PWRUP: begin
                if (!brk_en)
                    bst_nxt = B_READY;
                else if (bt_r >= brk_delay(2'd0))
                    bst_nxt = B_SETTLE;
            end
            B_SETTLE: begin
                if (bt_r >= brk_delay(2'd1))
                    bst_nxt = B_READY;
            end
            B_READY: begin
                if (!pwr_want && motor_stopped)
                    bst_nxt = brk_en ? B_STOPW : B_OFF;
            end
            B_STOPW: begin
                if (pwr_want)
                    bst_nxt = B_READY;
                else if (bt_r >= brk_delay(2'd2))
                    bst_nxt = B_ENG;
            end
            B_ENG: begin
                if (bt_r >= brk_delay(2'd3))
                    bst_nxt = bflags[`BMC_BFLAG_PWROFF] ? B_OFF : B_HOLD;
            end
            B_HOLD: begin
                if (pwr_want)
                    bst_nxt = B_PWRUP;
            end
            default: bst_nxt = B_OFF;
        endcase
    end

    always @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            bst_r <= B_OFF;
            bt_r <= 16'h0;
            motor_power_en <= 1'b0;
            brake_release <= 1'b0;
            move_ready <= 1'b0;
        end else begin
            bst_r <= bst_nxt;
            if (bst_nxt != bst_r)
                bt_r <= 16'h0;
            else if (ms_tick && bt_r != 16'hffff)
                bt_r <= bt_r + 16'h1;
            motor_power_en <= (bst_nxt != B_OFF);
            brake_release <= (bst_nxt == B_SETTLE) || (bst_nxt == B_READY) ||
                             (bst_nxt == B_STOPW);
            move_ready <= (bst_nxt == B_READY);
        end
    end

    // ==========================================
    // Manual control
    always @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            mst_r <= M_IDLE;
            mt_r <= 16'h0;
            lp_r <= 1'b0;
            rp_r <= 1'b0;
            man_run <= 1'b0;
            man_dir <= 1'b0;
            man_speed_index <= 4'h0;
            man_speed_full <= 32'h0;
            man_speed_frac <= 8'h00;
            man_profile_step <= 1'b0;
            pos_shift <= 32'h0;
            pos_shift_frac <= 16'h0;
        end else begin
            lp_r <= lp;
            rp_r <= rp;
            man_profile_step <= 1'b0;
            if (ms_tick && mt_r != 16'hffff)
                mt_r <= mt_r + 16'h1;
            man_speed_full <= {ctl_mem[sp_ofs + 6'd3], ctl_mem[sp_ofs + 6'd2],
                               ctl_mem[sp_ofs + 6'd1], ctl_mem[sp_ofs]};
            man_speed_frac <= ctl_mem[`BMC_OFS_FRAC + man_speed_index];
            pos_shift <= {ctl_mem[`BMC_OFS_SHIFT + 3], ctl_mem[`BMC_OFS_SHIFT + 2],
                          ctl_mem[`BMC_OFS_SHIFT + 1], ctl_mem[`BMC_OFS_SHIFT]};
            pos_shift_frac <= stepper_motor ? ctl_half(7'd`BMC_OFS_USHIFT) : 16'h0;
            if (mode == `BMC_MODE_STICK) begin
                mst_r <= M_IDLE;
                man_run <= stick_pos ^ stick_neg;
                man_dir <= stick_pos;
                // A click edge moves the kept index; a step up is refused when the next entry is empty.
                if (rp && !rp_r && man_speed_index != `BMC_LAST_IDX && !nxt_zero) begin
                    man_speed_index <= nxt_idx;
                    man_profile_step <= 1'b1;
                end else if (lp && !lp_r && man_speed_index != 4'h0) begin
                    man_speed_index <= man_speed_index - 4'h1;
                    man_profile_step <= 1'b1;
                end
            end else if (mode != `BMC_MODE_BUTTONS) begin
                mst_r <= M_IDLE;
                man_run <= 1'b0;
            end else begin
                case (mst_r)
                    M_IDLE: begin
                        man_run <= 1'b0;
                        if (lp ^ rp) begin
                            mst_r <= M_CLICK;
                            man_dir <= rp;
                            mt_r <= 16'h0;
                            man_speed_index <= 4'h0;
                        end
                    end
                    M_CLICK: begin
                        if (!(lp ^ rp)) begin
                            mst_r <= M_IDLE;
                        end else if (mt_r >= click_ms) begin
                            mst_r <= M_RUN;
                            mt_r <= 16'h0;
                            man_run <= 1'b1;
                        end
                    end
                    M_RUN: begin
                        if (!(lp ^ rp)) begin
                            mst_r <= M_IDLE;
                            man_run <= 1'b0;
                            man_speed_index <= 4'h0;
                        end else if (man_speed_index != `BMC_LAST_IDX &&
                                     mt_r >= tmo_ms) begin
                            man_speed_index <= nxt_idx;
                            mt_r <= 16'h0;
                            man_profile_step <= 1'b1;
                        end
                    end
                    default: mst_r <= M_IDLE;
                endcase
            end
        end
    end

    // ==========================================
    // Register port
    always @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            ctrl_r <= `BMC_CTRL_RST;
            reg_rdata <= 32'h0;
        end else begin
            if (reg_wr && reg_addr == `BMC_REG_CTRL)
                ctrl_r <= reg_wdata[0];
            if (reg_rd && reg_addr == `BMC_REG_CTRL)
                reg_rdata <= {31'h0, ctrl_r};
            else if (reg_rd && reg_addr == `BMC_REG_STATUS)
                reg_rdata <= {17'h0, bst_r, mst_r, mode, man_speed_index,
                              motor_power_en, brake_release, move_ready, man_run};
            else
                reg_rdata <= 32'h0;
        end
    end
endmodule // bmc_cmd_core
`default_nettype wire

// File: bmc_defs.vh
// Constants for the brake and manual control command handler.
`ifndef BMC_DEFS_VH
`define BMC_DEFS_VH
// ==========================================
// Command codes, first byte on the wire is the low byte
`define BMC_CODE_GET_BRAKE 32'h6b726267
`define BMC_CODE_SET_BRAKE 32'h6b726273
`define BMC_CODE_SET_CTL   32'h6c746373
`define BMC_CODE_GET_CTL   32'h6c746367
// ==========================================
// Frame lengths in bytes
`define BMC_LEN_CODE  7'd4
`define BMC_LEN_BRAKE 7'd25
`define BMC_LEN_CTL   7'd93
`define BMC_LEN_ACK   7'd4
// ==========================================
// Stored payload bytes, reserved bytes are not stored
`define BMC_BRK_USED 9
`define BMC_CTL_USED 78
`define BMC_BRK_FLAGS 8
`define BMC_OFS_SPEED  0
`define BMC_OFS_FRAC   40
`define BMC_OFS_TMO    50
`define BMC_OFS_CLICK  68
`define BMC_OFS_FLAGS  70
`define BMC_OFS_SHIFT  72
`define BMC_OFS_USHIFT 76
`define BMC_SPEEDS     10
`define BMC_LAST_IDX   4'd9
// ==========================================
// Flag bit positions and mode field values
`define BMC_BFLAG_ENABLE 0
`define BMC_BFLAG_PWROFF 1
`define BMC_CFLAG_LEFT   2
`define BMC_CFLAG_RIGHT  3
`define BMC_MODE_OFF     2'h0
`define BMC_MODE_STICK   2'h1
`define BMC_MODE_BUTTONS 2'h2
// ==========================================
// Timing and register map
`define BMC_MS_NS  1000000
`define BMC_CLK_NS 8
`define BMC_REG_CTRL   4'h0
`define BMC_REG_STATUS 4'h4
`define BMC_CTRL_RST   1'b0
`endif

// File: bmc_chk.sv
// Assertion checker for the brake and manual control command handler.
`timescale 1ns/1ps
`default_nettype none
module bmc_chk (
    input wire logic        clk_sys,
    input wire logic        rst_n,
    input wire logic        rx_ready,
    input wire logic [7:0]  tx_data,
    input wire logic        tx_valid,
    input wire logic        tx_ready,
    input wire logic        stepper_motor,
    input wire logic        motor_power_en,
    input wire logic        brake_release,
    input wire logic [3:0]  man_speed_index,
    input wire logic        man_profile_step,
    input wire logic [15:0] pos_shift_frac
);
    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (!rst_n);
    // ==========================================
    // Command link
    property p_rx_hold;
        tx_valid |-> !rx_ready;
    endproperty
    a_rx_hold: assert property (p_rx_hold) else $error("byte taken while answering");
    property p_tx_stand;
        tx_valid && !tx_ready |=> tx_valid && $stable(tx_data);
    endproperty
    a_tx_stand: assert property (p_tx_stand) else $error("answer byte not held");
    property p_ans_gap;
        $rose(tx_valid) |-> !$past(rx_ready) && $past(rx_ready, 2);
    endproperty
    a_ans_gap: assert property (p_ans_gap) else $error("answer start mistimed");
    // ==========================================
    // Brake and manual control
    property p_rel_pwr;
        $rose(brake_release) |-> motor_power_en;
    endproperty
    a_rel_pwr: assert property (p_rel_pwr) else $error("brake freed without power");
    property p_cut_braked;
        $fell(motor_power_en) |-> !brake_release;
    endproperty
    a_cut_braked: assert property (p_cut_braked) else $error("power cut, brake free");
    property p_frac_step;
        !stepper_motor |=> pos_shift_frac == 16'h0;
    endproperty
    a_frac_step: assert property (p_frac_step) else $error("fraction without stepper");
    property p_idx_step;
        man_speed_index != $past(man_speed_index) |-> man_speed_index == 4'h0
            || man_speed_index == $past(man_speed_index) + 4'h1
            || man_speed_index == $past(man_speed_index) - 4'h1;
    endproperty
    a_idx_step: assert property (p_idx_step) else $error("speed index jumped");
    property p_ramp;
        $changed(man_speed_index) && man_speed_index != 4'h0 |-> man_profile_step;
    endproperty
    a_ramp: assert property (p_ramp) else $error("index change without ramp");
    c_byte: cover property (tx_valid && tx_ready);
    c_cut: cover property ($fell(motor_power_en));
    c_idx: cover property ($changed(man_speed_index));
endmodule // bmc_chk
bind bmc_cmd_core bmc_chk i_bmc_chk (.clk_sys, .rst_n, .rx_ready, .tx_data, .tx_valid,
    .tx_ready, .stepper_motor, .motor_power_en, .brake_release, .man_speed_index,
    .man_profile_step, .pos_shift_frac);
`default_nettype wire

// File: bmc_host.sv
// Host model that sends command bytes and pulls answer bytes.
`timescale 1ns/1ps
`default_nettype none
module bmc_host (
    input  wire logic       clk_sys,
    output var  logic [7:0] rx_data,
    output var  logic       rx_valid,
    input  wire logic       rx_ready,
    input  wire logic [7:0] tx_data,
    input  wire logic       tx_valid,
    output var  logic       tx_ready
);
    initial begin
        rx_data = 8'h00;
        rx_valid = 1'b0;
        tx_ready = 1'b0;
    end
    task put(input logic [7:0] b);
        rx_data <= b;
        rx_valid <= 1'b1;
        for (int n = 0; n < 64; n++) begin
            @(posedge clk_sys);
            if (rx_ready === 1'b1)
                break;
        end
    endtask
    // Idle data is inverted so a stale byte never looks valid.
    task idle();
        rx_valid <= 1'b0;
        rx_data <= ~rx_data;
    endtask
    task get(output logic [7:0] b, output logic ok);
        ok = 1'b0;
        for (int n = 0; n < 64 && !ok; n++) begin
            tx_ready <= ($urandom % 3) != 0;
            @(posedge clk_sys);
            ok = tx_valid === 1'b1 && tx_ready === 1'b1;
            b = tx_data;
        end
    endtask
    task stop();
        tx_ready <= 1'b0;
    endtask
endmodule // bmc_host
`default_nettype wire

// File: bmc_cmd_core_bench.sv
// Self-checking bench for the brake and manual control command handler.
`timescale 1ns/1ps
`default_nettype none
`include "bmc_defs.vh"
module bmc_cmd_core_bench;
    localparam int MS = 10;
    logic clk_sys = 1'b0, rst_n = 1'b0, rx_valid, rx_ready, tx_valid, tx_ready;
    logic [7:0] rx_data, tx_data, man_speed_frac;
    logic [3:0] reg_addr = 4'h0, man_speed_index;
    logic [31:0] reg_wdata = 32'h0, reg_rdata, man_speed_full, pos_shift;
    logic reg_wr = 1'b0, reg_rd = 1'b0, power_req = 1'b0, motor_stopped = 1'b0;
    logic stepper_motor = 1'b0, btn_left_in = 1'b0, btn_right_in = 1'b0;
    logic stick_pos = 1'b0, stick_neg = 1'b0;
    logic motor_power_en, brake_release, move_ready, man_run, man_dir, man_profile_step;
    logic [15:0] pos_shift_frac;
    logic [7:0] fr [0:92];
    int fail_count = 0, n_checks = 0, n, t [4];
    bmc_cmd_core #(.MS_CYCLES(MS)) i_bmc_cmd_core (.clk_sys, .rst_n, .rx_data, .rx_valid,
        .rx_ready, .tx_data, .tx_valid, .tx_ready, .reg_addr, .reg_wdata, .reg_wr,
        .reg_rd, .reg_rdata, .power_req, .motor_stopped, .stepper_motor, .motor_power_en,
        .brake_release, .move_ready, .btn_left_in, .btn_right_in, .stick_pos, .stick_neg,
        .man_run, .man_dir, .man_speed_full, .man_speed_frac, .man_speed_index,
        .man_profile_step, .pos_shift, .pos_shift_frac);
    bmc_host i_bmc_host (.clk_sys, .rx_data, .rx_valid, .rx_ready, .tx_data, .tx_valid,
        .tx_ready);
    initial forever #4 clk_sys = ~clk_sys;
    // ==========================================
    // Helpers
    task chk(input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            fail_count++;
            $display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task tally_and_finish();
        $display("checks %0d mismatches %0d", n_checks, fail_count);
        if (fail_count == 0 && n_checks > 0)
            $display("ALL CHECKS OK");
        else
            $display("CHECKS NOT OK");
        $finish;
    endtask
    task do_reset();
        rst_n <= 1'b0;
        repeat (4) @(posedge clk_sys);
        rst_n <= 1'b1;
    endtask
    task reg_io(input logic [3:0] a, input logic [31:0] d, input logic wr,
                output logic [31:0] q);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= wr;
        reg_rd <= !wr;
        @(posedge clk_sys);
        reg_wr <= 1'b0;
        reg_rd <= 1'b0;
        @(posedge clk_sys);
        q = reg_rdata;
    endtask
    function automatic logic sig(int w);
        case (w)
            0: return motor_power_en;
            1: return brake_release;
            2: return move_ready;
            3: return man_run;
            4: return man_speed_index == 4'h1;
            default: return tx_valid;
        endcase
    endfunction
    task wait_for(input int w, input logic lvl, input int lim);
        for (n = 0; n < lim && sig(w) !== lvl; n++)
            @(posedge clk_sys);
    endtask
    task win(input int k);
        chk(32'(n >= (k - 1) * MS && n <= (k + 1) * MS + 4), 32'h1);
    endtask
    task code(input logic [31:0] c);
        {fr[3], fr[2], fr[1], fr[0]} = c;
    endtask
    task seal(input int len, input logic [31:0] c);
        logic [15:0] s;
        code(c);
        s = 16'h0;
        for (int i = 4; i < len - 2; i++)
            s += 16'(fr[i]);
        {fr[len - 1], fr[len - 2]} = s;
    endtask
    task send(input int len);
        for (int i = 0; i < len; i++)
            i_bmc_host.put(fr[i]);
        i_bmc_host.idle();
    endtask
    task expect_frame(input int len);
        logic [7:0] b;
        logic ok;
        for (int i = 0; i < len; i++) begin
            i_bmc_host.get(b, ok);
            chk({ok, b}, {1'b1, fr[i]});
        end
        i_bmc_host.stop();
    endtask
    // ==========================================
    // Main sequence
    initial begin
        logic [31:0] q;
        void'($urandom(24));
        do_reset();
        reg_io(`BMC_REG_CTRL, 32'h1, 1'b1, q);
        wait_for(2, 1'b1, 5);
        chk(32'(n < 5), 32'h1);
        reg_io(4'h8, 32'hffffffff, 1'b1, q);
        reg_io(4'h8, 32'h0, 1'b0, q);
        chk(q, 32'h0);
        do_reset();
        code(`BMC_CODE_GET_BRAKE);
        send(4);
        for (int i = 4; i < 25; i++)
            fr[i] = 8'h00;
        seal(25, `BMC_CODE_GET_BRAKE);
        expect_frame(25);
        for (int k = 0; k < 2; k++) begin
            for (int i = 0; i < 4; i++) begin
                t[i] = $urandom_range(3, 1);
                {fr[5 + 2 * i], fr[4 + 2 * i]} = 16'(t[i]);
            end
            fr[12] = k ? 8'h01 : 8'h03;
            for (int i = 13; i < 23; i++)
                fr[i] = 8'($urandom);
            seal(25, `BMC_CODE_SET_BRAKE);
            send(25);
            expect_frame(4);
            fr[4] ^= 8'h01;
            send(25);
            wait_for(5, 1'b1, 40);
            chk(n, 40);
            fr[4] ^= 8'h01;
            code(`BMC_CODE_GET_BRAKE);
            send(4);
            for (int i = 13; i < 23; i++)
                fr[i] = 8'h00;
            seal(25, `BMC_CODE_GET_BRAKE);
            expect_frame(25);
            motor_stopped <= 1'b0;
            if (k == 0)
                reg_io(`BMC_REG_CTRL, 32'h1, 1'b1, q);
            else
                power_req <= 1'b1;
            wait_for(0, 1'b1, 10);
            chk(32'(n < 10), 32'h1);
            wait_for(1, 1'b1, 5 * MS);
            win(t[0]);
            wait_for(2, 1'b1, 5 * MS);
            win(t[1]);
            reg_io(`BMC_REG_STATUS, 32'h0, 1'b0, q);
            chk(q[3:1], 3'b111);
            if (k == 0)
                reg_io(`BMC_REG_CTRL, 32'h0, 1'b1, q);
            power_req <= 1'b0;
            motor_stopped <= 1'b1;
            wait_for(1, 1'b0, 5 * MS);
            win(t[2]);
            wait_for(0, 1'b0, 5 * MS);
            if (k == 0)
                win(t[3]);
            else
                chk(n, 5 * MS);
        end
        stepper_motor <= 1'b1;
        btn_left_in <= 1'b1;
        for (int i = 4; i < 91; i++)
            fr[i] = (i >= 54 && i < 74) ? 8'(~i & 1) : 8'($urandom);
        for (int i = 0; i < 10; i++)
            fr[4 + 4 * i] |= 8'h01;
        {fr[75], fr[74]} = 16'h0006;
        seal(93, `BMC_CODE_SET_CTL);
        send(93);
        expect_frame(4);
        chk(pos_shift, {fr[79], fr[78], fr[77], fr[76]});
        chk(pos_shift_frac, {fr[81], fr[80]});
        btn_left_in <= 1'b0;
        wait_for(3, 1'b1, 4 * MS);
        win(1);
        chk({man_dir, man_speed_index}, 5'h00);
        wait_for(4, 1'b1, 4 * MS);
        win(1);
        repeat (2) @(posedge clk_sys);
        chk(man_speed_full, {fr[11], fr[10], fr[9], fr[8]});
        btn_left_in <= 1'b1;
        wait_for(3, 1'b0, 10);
        chk(32'(n < 10), 32'h1);
        btn_right_in <= 1'b1;
        wait_for(3, 1'b1, 4 * MS);
        chk({man_dir, man_speed_frac}, {1'b1, fr[44]});
        btn_right_in <= 1'b0;
        code(`BMC_CODE_GET_CTL);
        send(4);
        for (int i = 82; i < 91; i++)
            fr[i] = 8'h00;
        seal(93, `BMC_CODE_GET_CTL);
        expect_frame(93);
        fr[74] = 8'h01;
        seal(93, `BMC_CODE_SET_CTL);
        send(93);
        expect_frame(4);
        stick_pos <= 1'b1;
        repeat (3) @(posedge clk_sys);
        chk({man_run, man_dir, man_speed_index}, 6'h30);
        stepper_motor <= 1'b0;
        repeat (3) @(posedge clk_sys);
        chk(pos_shift_frac, 16'h0);
        tally_and_finish();
    end
endmodule // bmc_cmd_core_bench
`default_nettype wire
